// ---- hdl/occs_pkg.sv ----
// constants shared by the on/off cycle-skip switch controller
package occs_pkg;

    // ------------------------------------------------------------------
    // clock and oscillator timing
    // ------------------------------------------------------------------
    localparam int MCLK_HZ = 50_000_000;
    localparam int OSC_SLOW_HZ = 44_000;
    localparam int OSC_FAST_HZ = 130_000;
    localparam int DUTY_PCT = 67;
    localparam int OSC_W = 12;
    localparam logic [OSC_W-1:0] PERIOD_SLOW = OSC_W'(MCLK_HZ / OSC_SLOW_HZ);
    localparam logic [OSC_W-1:0] PERIOD_SLOW_X2 = OSC_W'(MCLK_HZ / (2 * OSC_SLOW_HZ));
    localparam logic [OSC_W-1:0] PERIOD_FAST = OSC_W'(MCLK_HZ / OSC_FAST_HZ);
    localparam logic [OSC_W-1:0] WIN_SLOW =
        OSC_W'((MCLK_HZ / OSC_SLOW_HZ) * DUTY_PCT / 100);
    localparam logic [OSC_W-1:0] WIN_SLOW_X2 =
        OSC_W'((MCLK_HZ / (2 * OSC_SLOW_HZ)) * DUTY_PCT / 100);
    localparam logic [OSC_W-1:0] WIN_FAST =
        OSC_W'((MCLK_HZ / OSC_FAST_HZ) * DUTY_PCT / 100);

    // turn-on blanking, in mclk cycles
    localparam int BLANK_W = 8;
    localparam int TURN_ON_BLANKING_CYCLES_DEF = 10;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CONDUCT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SKIP_OFS = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FAST_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int STAT_ON_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;
    localparam int STAT_UV_BIT = 2;
    localparam int STAT_OT_BIT = 3;
    localparam int STAT_FB_BIT = 4;

endpackage : occs_pkg

// ---- hdl/occs_hyst_latch.sv ----
// set/clear latch for a fault condition with hysteresis
`timescale 1ns/1ps
module occs_hyst_latch #(
    parameter bit RST_ACTIVE = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic setIn,
    input wire logic clearIn,
    output logic active
);

    logic active_q;
    logic active_d;

    // set wins so that a fresh fault is never lost under a clear
    assign active_d = setIn | (active_q & ~clearIn);
    assign active = active_q;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            active_q <= RST_ACTIVE;
        end else begin
            active_q <= active_d;
        end
    end

    a_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
        setIn |=> active) else $error("fault set did not latch");
    a_hold_till_clear: assert property (@(posedge mclk) disable iff (!nrst)
        active && !clearIn |=> active) else $error("fault dropped without clear");

endmodule : occs_hyst_latch

// ---- hdl/occs_oscillator.sv ----
// cycle oscillator: cycle-start pulse and max on-time window
`timescale 1ns/1ps
module occs_oscillator (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic fastSel,
    input wire logic doubleRate,
    output logic cycleStart,
    output logic dutyWindow
);

    logic [occs_pkg::OSC_W-1:0] count_q;
    logic [occs_pkg::OSC_W-1:0] count_d;
    logic [occs_pkg::OSC_W-1:0] periodEnd;
    logic [occs_pkg::OSC_W-1:0] winEnd;
    logic lastTick;
    logic [occs_pkg::OSC_W-1:0] startGap_q;
    logic [occs_pkg::OSC_W-1:0] startGap_d;

    assign periodEnd = fastSel ? occs_pkg::PERIOD_FAST :
        (doubleRate ? occs_pkg::PERIOD_SLOW_X2 : occs_pkg::PERIOD_SLOW);
    assign winEnd = fastSel ? occs_pkg::WIN_FAST :
        (doubleRate ? occs_pkg::WIN_SLOW_X2 : occs_pkg::WIN_SLOW);

    // >= guards the wrap when the rate shortens mid-cycle
    assign lastTick = (count_q >= periodEnd - 12'h001);
    assign count_d = lastTick ? 12'h000 : count_q + 12'h001;
    assign cycleStart = (count_q == 12'h000);
    assign dutyWindow = (count_q < winEnd);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count_q <= 12'h000;
        end else begin
            count_q <= count_d;
        end
    end

    // checker helper: edges since the last start, saturating so a stall stays visible
    assign startGap_d = cycleStart ? 12'h000 :
        ((startGap_q == 12'hfff) ? startGap_q : startGap_q + 12'h001);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            startGap_q <= 12'h000;
        end else begin
            startGap_q <= startGap_d;
        end
    end

    a_period_bound: assert property (@(posedge mclk) disable iff (!nrst)
        count_q < occs_pkg::PERIOD_SLOW) else $error("cycle longer than slow period");
    a_window_start: assert property (@(posedge mclk) disable iff (!nrst)
        cycleStart |-> dutyWindow [*8]) else $error("window not open at cycle start");
    a_double_rate: assert property (@(posedge mclk) disable iff (!nrst)
        doubleRate && !fastSel && count_q == occs_pkg::PERIOD_SLOW_X2 - 12'h001
        |=> cycleStart) else $error("skip rate not doubled");
    a_clock_runs: assert property (@(posedge mclk) disable iff (!nrst)
        startGap_q < occs_pkg::PERIOD_SLOW) else $error("cycle clock stalled");

endmodule : occs_oscillator

// ---- hdl/occs_switch_ctrl.sv ----
// on/off cycle-skip power switch controller with apb status and control
//
// Overview of operation
// - oscillator runs at 44 kHz nominal, 130 kHz in the fast variant.
// - max on-time window is high for 67% of each period from start.
// - feedback is sampled once, at each cycle start.
// - high sample turns the switch on; low sample skips the cycle.
// - feedback changes after the sample are ignored until next start.
// - skipping doubles the oscillator rate, except in the fast variant.
// - switch held off below 5.1 V supply until it regains 5.8 V.
// - switch held off above 135 C until temperature drops by 70 C.
// - current over limit turns the switch off for the rest of the cycle.
// - current limit ignored during a blanking interval after turn-on.
// - switch forced off when the max on-time window ends.
// - cycle clock runs continuously and feedback is rechecked every cycle.
`timescale 1ns/1ps
module occs_switch_ctrl #(
    parameter int TURN_ON_BLANKING_CYCLES = occs_pkg::TURN_ON_BLANKING_CYCLES_DEF,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [occs_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic feedbackIn,
    input wire logic internalSupplyNodeLow,
    input wire logic internalSupplyNodeGood,
    input wire logic tempHigh,
    input wire logic tempCooled,
    input wire logic currentOverLimit,
    output logic switchOn,
    output logic cycleClk,
    output logic maxOnTimeLimit
);

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (TURN_ON_BLANKING_CYCLES < 1 || TURN_ON_BLANKING_CYCLES > 255) begin : g_bad_blank
        $error("blanking count must be 1 to 255");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("counter width must be 1 to 32");
    end

    localparam logic [occs_pkg::BLANK_W-1:0] BLANK_LOAD =
        occs_pkg::BLANK_W'(TURN_ON_BLANKING_CYCLES);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic cycleStart;
    logic dutyWindow;
    logic uvloActive;
    logic otpActive;
    logic faultHold;
    logic startOk;
    logic limitTrip;
    logic keepOn;
    logic doubleRate;
    logic switchOn_q;
    logic switchOn_d;
    logic skip_q;
    logic skip_d;
    logic lastSample_q;
    logic cycleClk_q;
    logic window_q;
    logic [occs_pkg::BLANK_W-1:0] blankCnt_q;
    logic [occs_pkg::BLANK_W-1:0] blankCnt_d;
    logic blankDone;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [CNT_W-1:0] conductCnt_q;
    logic [CNT_W-1:0] skipCnt_q;
    logic [31:0] prdata_q;
    logic [31:0] readMux;
    logic setupRd;
    logic accessWr;
    logic hitCtrl;
    logic hitStatus;
    logic hitConduct;
    logic hitSkip;
    logic addrHit;
    logic ctrlWr;
    logic cntClear;
    logic switchEnable;
    logic fastSel;

    // ------------------------------------------------------------------
    // oscillator and protection latches
    // ------------------------------------------------------------------
    // skip doubling
    assign doubleRate = skip_q & ~fastSel;

    occs_oscillator u_osc (
        .mclk(mclk),
        .nrst(nrst),
        .fastSel(fastSel),
        .doubleRate(doubleRate),
        .cycleStart(cycleStart),
        .dutyWindow(dutyWindow)
    );

    // undervoltage hysteresis; starts locked out until supply is good
    occs_hyst_latch #(
        .RST_ACTIVE(1'b1)
    ) u_uvlo (
        .mclk(mclk),
        .nrst(nrst),
        .setIn(internalSupplyNodeLow),
        .clearIn(internalSupplyNodeGood),
        .active(uvloActive)
    );

    occs_hyst_latch #(
        .RST_ACTIVE(1'b0)
    ) u_otp (
        .mclk(mclk),
        .nrst(nrst),
        .setIn(tempHigh),
        .clearIn(tempCooled),
        .active(otpActive)
    );

    // ------------------------------------------------------------------
    // switch gating
    // ------------------------------------------------------------------
    assign faultHold = uvloActive | otpActive;
    assign startOk = cycleStart & feedbackIn & ~faultHold & switchEnable;
    assign blankDone = (blankCnt_q == 8'h00);
    assign limitTrip = currentOverLimit & blankDone;
    // window end, faults cut a running pulse
    assign keepOn = switchOn_q & dutyWindow & ~faultHold & ~limitTrip;
    // only a start edge can turn the switch on
    assign switchOn_d = cycleStart ? startOk : keepOn;
    assign skip_d = cycleStart ? ~startOk : skip_q;
    assign blankCnt_d = startOk ? BLANK_LOAD :
        (blankDone ? blankCnt_q : blankCnt_q - 8'h01);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            switchOn_q <= 1'b0;
            skip_q <= 1'b0;
            blankCnt_q <= 8'h00;
            lastSample_q <= 1'b0;
            cycleClk_q <= 1'b0;
            window_q <= 1'b0;
        end else begin
            switchOn_q <= switchOn_d;
            skip_q <= skip_d;
            blankCnt_q <= blankCnt_d;
            lastSample_q <= cycleStart ? feedbackIn : lastSample_q;
            cycleClk_q <= cycleStart;
            window_q <= dutyWindow;
        end
    end

    assign switchOn = switchOn_q;
    assign cycleClk = cycleClk_q;
    assign maxOnTimeLimit = window_q;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // zero wait states: read data is latched in the setup cycle
    assign pready = 1'b1;
    assign hitCtrl = (paddr == occs_pkg::CTRL_OFS);
    assign hitStatus = (paddr == occs_pkg::STATUS_OFS);
    assign hitConduct = (paddr == occs_pkg::CONDUCT_OFS);
    assign hitSkip = (paddr == occs_pkg::SKIP_OFS);
    assign addrHit = hitCtrl | hitStatus | hitConduct | hitSkip;
    assign pslverr = psel & penable & ~addrHit;
    assign setupRd = psel & ~penable & ~pwrite;
    assign accessWr = psel & penable & pwrite;
    assign ctrlWr = accessWr & hitCtrl;
    assign cntClear = ctrlWr & pwdata[occs_pkg::CTRL_CLR_BIT];
    assign ctrl_d = ctrlWr ?
        {pwdata[occs_pkg::CTRL_FAST_BIT], pwdata[occs_pkg::CTRL_EN_BIT]} : ctrl_q;
    assign switchEnable = ctrl_q[occs_pkg::CTRL_EN_BIT];
    assign fastSel = ctrl_q[occs_pkg::CTRL_FAST_BIT];

    always_comb begin
        readMux = 32'h0000_0000;
        if (hitCtrl) begin
            readMux[occs_pkg::CTRL_EN_BIT] = switchEnable;
            readMux[occs_pkg::CTRL_FAST_BIT] = fastSel;
        end else if (hitStatus) begin
            readMux[occs_pkg::STAT_ON_BIT] = switchOn_q;
            readMux[occs_pkg::STAT_SKIP_BIT] = skip_q;
            readMux[occs_pkg::STAT_UV_BIT] = uvloActive;
            readMux[occs_pkg::STAT_OT_BIT] = otpActive;
            readMux[occs_pkg::STAT_FB_BIT] = lastSample_q;
        end else if (hitConduct) begin
            readMux = 32'(conductCnt_q);
        end else if (hitSkip) begin
            readMux = 32'(skipCnt_q);
        end
    end

    // saturating event counter; an event in the clear cycle still counts
    function automatic logic [CNT_W-1:0] bumpCount(
        input logic [CNT_W-1:0] v,
        input logic clr,
        input logic inc
    );
        logic [CNT_W-1:0] base;
        base = clr ? '0 : v;
        if (inc && base != '1) begin
            base = base + 1'b1;
        end
        return base;
    endfunction : bumpCount

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q <= occs_pkg::CTRL_RST;
            prdata_q <= 32'h0000_0000;
            conductCnt_q <= '0;
            skipCnt_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            prdata_q <= setupRd ? readMux : prdata_q;
            conductCnt_q <= bumpCount(conductCnt_q, cntClear, startOk);
            skipCnt_q <= bumpCount(skipCnt_q, cntClear, cycleStart & ~startOk);
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_conduct_on_high: assert property (
        cycleStart && feedbackIn && !faultHold && switchEnable |=> switchOn_q)
        else $error("switch did not turn on for high sample");
    a_skip_on_low: assert property (
        cycleStart && !feedbackIn |=> !switchOn_q [*2])
        else $error("switch turned on for low sample");
    a_turn_on_start: assert property (
        $rose(switchOn_q) |-> $past(cycleStart))
        else $error("switch turned on away from cycle start");
    a_stay_off_cycle: assert property (
        !switchOn_q && !cycleStart |=> !switchOn_q)
        else $error("switch turned on mid-cycle");
    a_uvlo_hold: assert property (
        uvloActive |=> !switchOn_q)
        else $error("switch on during undervoltage");
    a_thermal_hold: assert property (
        otpActive |=> !switchOn_q)
        else $error("switch on during over-temperature");
    a_limit_cut: assert property (
        switchOn_q && currentOverLimit && blankDone && !cycleStart |=> !switchOn_q)
        else $error("current limit did not end pulse");
    a_blank_ignore: assert property (
        switchOn_q && !blankDone && dutyWindow && !faultHold && !cycleStart
        |=> switchOn_q)
        else $error("pulse ended during blanking");
    a_window_cut: assert property (
        !dutyWindow |=> !switchOn_q)
        else $error("switch on past max on-time window");
    a_blank_load: assert property (
        $rose(switchOn_q) |-> blankCnt_q == BLANK_LOAD)
        else $error("blanking count not loaded at turn-on");
    a_enable_gate: assert property (
        cycleStart && !switchEnable |=> !switchOn_q)
        else $error("switch on while disabled");
    a_last_sample: assert property (
        cycleStart |=> lastSample_q == $past(feedbackIn))
        else $error("feedback sample not held");
    a_skip_flag: assert property (
        cycleStart |=> skip_q == !$past(startOk))
        else $error("skip flag wrong");
    a_cycle_clk: assert property (
        cycleStart |=> cycleClk)
        else $error("cycle clock missed a start");
    a_clk_single: assert property (
        cycleClk |=> !cycleClk)
        else $error("cycle clock too long");
    a_window_open: assert property (
        dutyWindow |=> maxOnTimeLimit)
        else $error("window output low in window");
    a_window_closed: assert property (
        !dutyWindow |=> !maxOnTimeLimit)
        else $error("window output high past window");

    // ------------------------------------------------------------------
    // register bus assertions
    // ------------------------------------------------------------------
    a_slverr_unmapped: assert property (
        psel && penable && paddr != occs_pkg::CTRL_OFS && paddr != occs_pkg::STATUS_OFS
        && paddr != occs_pkg::CONDUCT_OFS && paddr != occs_pkg::SKIP_OFS |-> pslverr)
        else $error("no slave error on unmapped address");
    a_slverr_idle: assert property (
        !(psel && penable) |-> !pslverr)
        else $error("slave error outside access");
    a_prdata_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_ctrl_write: assert property (
        psel && penable && pwrite && paddr == occs_pkg::CTRL_OFS |=>
        switchEnable == $past(pwdata[occs_pkg::CTRL_EN_BIT])
        && fastSel == $past(pwdata[occs_pkg::CTRL_FAST_BIT]))
        else $error("control write lost");
    a_ctrl_hold: assert property (
        !(psel && penable && pwrite && paddr == occs_pkg::CTRL_OFS) |=> $stable(ctrl_q))
        else $error("control changed without a write");
    a_status_read: assert property (
        psel && !penable && !pwrite && paddr == occs_pkg::STATUS_OFS |=>
        prdata[occs_pkg::STAT_ON_BIT] == $past(switchOn_q)
        && prdata[occs_pkg::STAT_SKIP_BIT] == $past(skip_q))
        else $error("status read wrong");
    a_count_clear: assert property (
        cntClear && !cycleStart |=> conductCnt_q == '0 && skipCnt_q == '0)
        else $error("counters not cleared");
    a_conduct_count: assert property (
        startOk && !cntClear && conductCnt_q != '1
        |=> conductCnt_q == $past(conductCnt_q) + 1'b1)
        else $error("conduction count missed");
    a_skip_count: assert property (
        cycleStart && !startOk && !cntClear && skipCnt_q != '1
        |=> skipCnt_q == $past(skipCnt_q) + 1'b1)
        else $error("skip count missed");
    a_count_idle: assert property (
        !cycleStart && !cntClear |=> $stable(conductCnt_q) && $stable(skipCnt_q))
        else $error("counter moved between starts");

    c_conduct: cover property ($rose(switchOn_q) ##[1:400] $fell(switchOn_q));
    c_skip: cover property (cycleStart && !feedbackIn ##1 doubleRate);
    c_limit: cover property (switchOn_q && limitTrip);
    c_window_end: cover property (switchOn_q && !dutyWindow);
    c_fast: cover property (fastSel && cycleStart ##1 switchOn_q);

endmodule : occs_switch_ctrl

// ---- tb/occs_fb_party.sv ----
// feedback party model: secondary-side regulator driving the feedback input
`timescale 1ns/1ps
module occs_fb_party (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic needPower,
    input wire logic slowLink,
    input wire logic wiggle,
    output logic feedbackIn
);
    logic [7:0] lag_q;
    logic tog_q;

    // optocoupler path is slow; the lag line gives a prompt and a late answer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lag_q <= 8'h00;
            tog_q <= 1'b0;
        end else begin
            lag_q <= {lag_q[6:0], needPower};
            tog_q <= ~tog_q;
        end
    end

    assign feedbackIn = wiggle ? tog_q : (slowLink ? lag_q[7] : lag_q[0]);
endmodule : occs_fb_party

// ---- tb/test_occs_switch_ctrl.sv ----
// self-checking bench for the cycle-skip switch controller
`timescale 1ns/1ps
module test_occs_switch_ctrl;
    localparam int BLANK = 6;
    logic mclk, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, feedbackIn, switchOn, cycleClk, maxOnTimeLimit;
    logic internalSupplyNodeLow = 1'b0, internalSupplyNodeGood = 1'b1;
    logic tempHigh = 1'b0, tempCooled = 1'b0, currentOverLimit = 1'b0;
    logic needPower = 1'b0, slowLink = 1'b0, wiggle = 1'b0;
    int errCount = 0, samplesChecked = 0, seed = 13;
    bit en = 1, fast = 0, uvM = 0, otM = 0, lim = 0, ign = 1;
    bit prevOn, prevFast, prevLim, expOn, fbPrev;
    int gap, onLen, winLen, condM = 0, skipM = 0, pw, ww;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    occs_switch_ctrl #(.TURN_ON_BLANKING_CYCLES(BLANK)) i_dut (
        .mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .feedbackIn(feedbackIn),
        .internalSupplyNodeLow(internalSupplyNodeLow),
        .internalSupplyNodeGood(internalSupplyNodeGood), .tempHigh(tempHigh),
        .tempCooled(tempCooled), .currentOverLimit(currentOverLimit),
        .switchOn(switchOn), .cycleClk(cycleClk), .maxOnTimeLimit(maxOnTimeLimit)
    );

    occs_fb_party i_fb (
        .mclk(mclk), .nrst(nrst), .needPower(needPower), .slowLink(slowLink),
        .wiggle(wiggle), .feedbackIn(feedbackIn)
    );

    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
            errCount++;
        end
    endtask : chk

    task automatic endOfTest();
        $display("checks %0d, mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : endOfTest

    // ------------------------------------------------------------------
    // cycle model: judges each finished cycle at the next cycle start, except the first after reset or a control write
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (nrst !== 1'b1) begin
            gap = 0;
            ign = 1;
        end else if (cycleClk === 1'b1) begin
            pw = prevFast ? int'(occs_pkg::PERIOD_FAST) :
                (prevOn ? int'(occs_pkg::PERIOD_SLOW) : int'(occs_pkg::PERIOD_SLOW_X2));
            ww = prevFast ? int'(occs_pkg::WIN_FAST) :
                (prevOn ? int'(occs_pkg::WIN_SLOW) : int'(occs_pkg::WIN_SLOW_X2));
            if (!ign) begin
                chk("period", pw, gap);
                chk("window", ww, winLen);
                chk("on time", !prevOn ? 0 : (prevLim ? BLANK + 1 : ww), onLen);
            end
            expOn = fbPrev && en && !uvM && !otM;
            chk("switch at start", 32'(expOn), 32'(switchOn));
            if (expOn)
                condM++;
            else
                skipM++;
            prevOn = expOn;
            prevFast = fast;
            prevLim = lim;
            ign = 0;
            gap = 1;
            onLen = int'(switchOn);
            winLen = int'(maxOnTimeLimit);
        end else begin
            gap++;
            onLen += int'(switchOn);
            winLen += int'(maxOnTimeLimit);
        end
        fbPrev = feedbackIn;
    end

    // ------------------------------------------------------------------
    // bus and sequencing tasks
    // ------------------------------------------------------------------
    task automatic waitPulses(input int n);
        int t;
        repeat (n) begin
            t = 0;
            @(posedge mclk);
            while (cycleClk !== 1'b1 && t < 2000) begin
                @(posedge mclk);
                t++;
            end
            if (t >= 2000) begin
                $display("unexpected timeout waiting for a cycle start");
                errCount++;
                endOfTest();
            end
        end
        // one edge more, so model updates never race the monitor
        @(posedge mclk);
    endtask : waitPulses

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int t;
        t = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) begin
            $display("unexpected timeout waiting for pready");
            errCount++;
            endOfTest();
        end
    endtask : apb

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr,
                         input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(what, exp, q);
        chk("slave error", 32'(expErr), 32'(e));
    endtask : rdChk

    task automatic ctrlWrite(input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, occs_pkg::CTRL_OFS, d, q, e);
        en = d[0];
        fast = d[1];
        ign = 1'b1;
        if (d[2]) begin
            condM = 0;
            skipM = 0;
        end
    endtask : ctrlWrite

    task automatic quiet();
        needPower <= 1'b0;
        waitPulses(2);
    endtask : quiet

    // holds the switch off through the hysteresis band of one fault
    task automatic faultSeq(input int k);
        logic [31:0] q;
        logic e;
        quiet();
        if (k == 0) begin
            internalSupplyNodeLow <= 1'b1;
            internalSupplyNodeGood <= 1'b0;
            uvM = 1;
        end else begin
            tempHigh <= 1'b1;
            otM = 1;
        end
        needPower <= 1'b1;
        waitPulses(2);
        apb(1'b0, occs_pkg::STATUS_OFS, 32'h0, q, e);
        chk("fault flag", (k == 0) ? 32'h4 : 32'h8, q & 32'hc);
        internalSupplyNodeLow <= 1'b0;
        tempHigh <= 1'b0;
        waitPulses(2);
        internalSupplyNodeGood <= 1'b1;
        tempCooled <= (k == 1);
        uvM = 0;
        otM = 0;
        waitPulses(3);
        tempCooled <= 1'b0;
    endtask : faultSeq

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rdChk(occs_pkg::CTRL_OFS, 32'h1, 1'b0, "control reset value");
        rdChk(8'h10, 32'h0, 1'b1, "unmapped read");
        $display("test registers done");
        needPower <= 1'b1;
        waitPulses(4);
        $display("test steady conduction done");
        repeat (8) begin
            needPower <= 1'($random(seed));
            slowLink <= 1'($random(seed));
            waitPulses(1);
        end
        $display("test random skipping done");
        wiggle <= 1'b1;
        waitPulses(6);
        wiggle <= 1'b0;
        $display("test mid-cycle feedback done");
        quiet();
        currentOverLimit <= 1'b1;
        lim = 1;
        needPower <= 1'b1;
        waitPulses(4);
        quiet();
        currentOverLimit <= 1'b0;
        lim = 0;
        $display("test current limit done");
        faultSeq(0);
        faultSeq(1);
        $display("test fault hysteresis done");
        ctrlWrite(32'h3);
        repeat (6) begin
            needPower <= 1'($random(seed));
            waitPulses(1);
        end
        ctrlWrite(32'h0);
        needPower <= 1'b1;
        waitPulses(3);
        ctrlWrite(32'h1);
        waitPulses(2);
        $display("test fast variant and enable done");
        rdChk(occs_pkg::CONDUCT_OFS, condM, 1'b0, "conduct count");
        rdChk(occs_pkg::SKIP_OFS, skipM, 1'b0, "skip count");
        ctrlWrite(32'h5);
        rdChk(occs_pkg::CONDUCT_OFS, 32'h0, 1'b0, "cleared conduct count");
        rdChk(occs_pkg::SKIP_OFS, 32'h0, 1'b0, "cleared skip count");
        $display("test counters done");
        endOfTest();
    end
endmodule : test_occs_switch_ctrl
